// File: rtl/intc_cfg_regs.svh
// register offsets, field positions, reset values and constants
// Contract
// - vector mode bit 12 set selects multi-vectored dispatch per source
// - vector mode bit cleared selects single-vectored dispatch, one vector
// - threshold field bits 10..8 picks priorities that start proximity timer
// - threshold 000 disables the proximity timer completely
// - threshold 001 lets only priority 1 start the timer
// - threshold 010..111 lets priorities at or below value start timer
// - bit 4 sets edge of external input 4, 1 rising, 0 falling
// - bit 3 sets edge of external input 3, 1 rising, 0 falling
// - bit 2 sets edge of external input 2, 1 rising, 0 falling
// - bit 1 sets edge of external input 1, 1 rising, 0 falling
// - bit 0 sets edge of external input 0, 1 rising, 0 falling
// - bits 31..16, 15..13, 7..5 read zero, writes ignored
// - bit 11 reads zero
`ifndef INTC_CFG_REGS_SVH
`define INTC_CFG_REGS_SVH

`define OFS_CONTROL     8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_PRIORITY    8'h0C
`define OFS_PROX_TIME   8'h10
`define OFS_VECTOR      8'h14

`define POS_VEC_MODE    12
`define POS_THRESH_HI   10
`define POS_THRESH_LO   8
`define POS_EDGE_HI     4
`define POS_EDGE_LO     0

`define RST_CONTROL     9'h000
`define RST_STATUS      6'h00
`define RST_MASK        6'h00
`define RST_PRIORITY    15'h0000
`define RST_PROX_TIME   16'h0010

`define POS_PROX_EVENT  5
`define THRESH_OFF      3'h0

`endif

// File: rtl/intc_cfg_pkg.sv
// types shared by the interrupt configuration block
package intc_cfg_pkg;

	typedef struct packed {
		logic       vecMode;
		logic [2:0] proxThresh;
		logic [4:0] edgeSel;
	} ctrl_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wrData;
		logic        wrStb;
		logic        rdStb;
	} bus_req_t;

	typedef enum logic [1:0] {
		PROX_IDLE = 2'b00,
		PROX_RUN  = 2'b01,
		PROX_DONE = 2'b10
	} prox_state_t;

endpackage

// File: rtl/ext_edge_detect.sv
// pin synchroniser and polarity-selected edge detector
`timescale 1ns/1ps
module ext_edge_detect #(
	parameter int WIDTH = 5
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// pins and polarity
	input  wire logic [WIDTH-1:0] pinIn,
	input  wire logic [WIDTH-1:0] risingSel,
	// detected events
	output logic      [WIDTH-1:0] edgeEvt
);

	logic [WIDTH-1:0] sync1;
	logic [WIDTH-1:0] sync2;
	logic [WIDTH-1:0] sync3;
	logic [WIDTH-1:0] stable;
	logic [WIDTH-1:0] agreed;
	logic [WIDTH-1:0] changed;

	assign agreed  = ~(sync2 ^ sync3);
	assign changed = agreed & (sync3 ^ stable);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else if (ce) begin
			sync1 <= pinIn;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// filtered level and edge pulse of chosen polarity
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stable  <= '0;
			edgeEvt <= '0;
		end else if (ce) begin
			stable  <= stable ^ changed;
			edgeEvt <= changed & ~(sync3 ^ risingSel);
		end
	end

endmodule

// File: rtl/interrupt_control_config.sv
// interrupt controller configuration, status and dispatch
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "intc_cfg_regs.svh"
module interrupt_control_config #(
	parameter int NUM_EXT   = 5,
	parameter int PRIO_W    = 3,
	parameter int PROX_W    = 16
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        ce,
	// register port
	input  wire intc_cfg_pkg::bus_req_t      busReq,
	output logic      [31:0]                 rdData,
	// external interrupt pins
	input  wire logic [NUM_EXT-1:0]          extIrqPin,
	// towards the processor core
	output logic                             coreIrq,
	output logic      [7:0]                  coreVector,
	output logic                             vectorModeSelect,
	output logic                             proxTimerActive
);

	localparam int NSRC = NUM_EXT + 1;

	intc_cfg_pkg::ctrl_t        ctrl;
	intc_cfg_pkg::prox_state_t  proxState;
	intc_cfg_pkg::prox_state_t  next_proxState;
	logic [NSRC-1:0]            status;
	logic [NSRC-1:0]            mask;
	logic [NUM_EXT*PRIO_W-1:0]  groupPrio;
	logic [PROX_W-1:0]          proxTime;
	logic [PROX_W-1:0]          proxCount;
	logic [NUM_EXT-1:0]         edgeEvt;
	logic [NSRC-1:0]            events;
	logic [NSRC-1:0]            pending;
	logic [NUM_EXT-1:0]         qualify;
	logic [NUM_EXT-1:0]         held;
	logic [NSRC-1:0]            deliver;
	logic                       proxExpire;
	logic                       wrHit;
	logic                       rdStatus;
	logic [31:0]                next_rdData;
	logic [7:0]                 next_vector;
	logic [7:0]                 bestIdx;
	logic                       wrCtrl;
	logic                       wrMask;
	logic                       wrPrio;
	logic                       wrProx;
	logic [NSRC-1:0]            next_status;

	// group priority of one external source
	function automatic logic [PRIO_W-1:0] prioOf(
		input logic [NUM_EXT*PRIO_W-1:0] pr,
		input int                        idx
	);
		prioOf = pr[idx*PRIO_W +: PRIO_W];
	endfunction

	// threshold test for coalescing
	function automatic logic startsTimer(
		input logic [2:0]        thr,
		input logic [PRIO_W-1:0] p
	);
		logic r;
		r = 1'b0;
		if (thr == `THRESH_OFF) begin
			r = 1'b0;
		end else if (thr == 3'h1) begin
			r = (p == 3'h1);
		end else begin
			r = (p <= thr);
		end
		startsTimer = r;
	endfunction

	// register select decode
	function automatic logic isAddr(
		input logic [7:0] a,
		input logic [7:0] ofs
	);
		isAddr = (a == ofs);
	endfunction

	// synchronised edge events per pin
	ext_edge_detect #(
		.WIDTH(NUM_EXT)
	) i_ext_edge_detect (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.ce       (ce),
		.pinIn    (extIrqPin),
		.risingSel(ctrl.edgeSel),
		.edgeEvt  (edgeEvt)
	);

	assign wrHit    = ce && busReq.wrStb;
	assign rdStatus = busReq.rdStb && isAddr(busReq.addr, `OFS_STATUS);
	assign pending  = status & mask;

	// event vector, proximity expiry above the pins
	always_comb begin
		events              = '0;
		events[NUM_EXT-1:0] = edgeEvt;
		events[NSRC-1]      = proxExpire;
	end

	// write enables per register
	always_comb begin
		wrCtrl = 1'b0;
		wrMask = 1'b0;
		wrPrio = 1'b0;
		wrProx = 1'b0;
		if (wrHit) begin
			wrCtrl = isAddr(busReq.addr, `OFS_CONTROL);
			wrMask = isAddr(busReq.addr, `OFS_MASK);
			wrPrio = isAddr(busReq.addr, `OFS_PRIORITY);
			wrProx = isAddr(busReq.addr, `OFS_PROX_TIME);
		end
	end

	// control register, unimplemented bits never stored
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= `RST_CONTROL;
		end else if (wrCtrl) begin
			ctrl.vecMode    <= busReq.wrData[`POS_VEC_MODE];
			ctrl.proxThresh <= busReq.wrData[`POS_THRESH_HI:`POS_THRESH_LO];
			ctrl.edgeSel    <= busReq.wrData[`POS_EDGE_HI:`POS_EDGE_LO];
		end
	end

	// mask register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask <= `RST_MASK;
		end else if (wrMask) begin
			mask <= busReq.wrData[NSRC-1:0];
		end
	end

	// priority register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			groupPrio <= `RST_PRIORITY;
		end else if (wrPrio) begin
			groupPrio <= busReq.wrData[NUM_EXT*PRIO_W-1:0];
		end
	end

	// proximity reload register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			proxTime <= `RST_PROX_TIME;
		end else if (wrProx) begin
			proxTime <= busReq.wrData[PROX_W-1:0];
		end
	end

	// read clears, an event in the same cycle wins
	always_comb begin
		next_status = rdStatus ? '0 : status;
		next_status = next_status | events;
	end

	// sticky status register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status <= `RST_STATUS;
		end else if (ce) begin
			status <= next_status;
		end
	end

	// which pending sources the timer may hold back
	always_comb begin
		qualify = '0;
		for (int i = 0; i < NUM_EXT; i++) begin
			qualify[i] = pending[i] &&
				startsTimer(ctrl.proxThresh, prioOf(groupPrio, i));
		end
	end

	// qualifying sources wait until the timer expires
	always_comb begin
		if (proxState == intc_cfg_pkg::PROX_DONE) begin
			held = '0;
		end else begin
			held = qualify;
		end
		deliver = pending & ~{1'b0, held};
	end

	// proximity timer state
	always_comb begin
		next_proxState = proxState;
		case (proxState)
			intc_cfg_pkg::PROX_IDLE: begin
				if (|qualify) begin
					next_proxState = intc_cfg_pkg::PROX_RUN;
				end
			end
			intc_cfg_pkg::PROX_RUN: begin
				if (ctrl.proxThresh == `THRESH_OFF) begin
					next_proxState = intc_cfg_pkg::PROX_IDLE;
				end else if (proxCount == '0) begin
					next_proxState = intc_cfg_pkg::PROX_DONE;
				end
			end
			intc_cfg_pkg::PROX_DONE: begin
				if (~|qualify) begin
					next_proxState = intc_cfg_pkg::PROX_IDLE;
				end
			end
			default: begin
				next_proxState = intc_cfg_pkg::PROX_IDLE;
			end
		endcase
	end

	assign proxExpire = (proxState == intc_cfg_pkg::PROX_RUN) &&
		(next_proxState == intc_cfg_pkg::PROX_DONE);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			proxState <= intc_cfg_pkg::PROX_IDLE;
		end else if (ce) begin
			proxState <= next_proxState;
		end
	end

	// proximity down counter
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			proxCount <= '0;
		end else if (ce) begin
			if (proxState != intc_cfg_pkg::PROX_RUN) begin
				proxCount <= proxTime;
			end else if (proxCount != '0) begin
				proxCount <= proxCount - 1'b1;
			end
		end
	end

	// highest group priority deliverable source, lowest index on ties
	always_comb begin
		logic [PRIO_W-1:0] bestPr;
		logic              found;
		bestPr  = '0;
		found   = 1'b0;
		bestIdx = '0;
		for (int i = 0; i < NUM_EXT; i++) begin
			if (deliver[i] && (!found || prioOf(groupPrio, i) > bestPr)) begin
				bestPr  = prioOf(groupPrio, i);
				bestIdx = 8'(i);
				found   = 1'b1;
			end
		end
		if (!found && deliver[NSRC-1]) begin
			bestIdx = 8'(NSRC-1);
		end
	end

	// vector number per source or shared
	always_comb begin
		if (ctrl.vecMode) begin
			next_vector = bestIdx + 8'h01;
		end else begin
			next_vector = 8'h00;
		end
	end

	// request towards the core
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			coreIrq <= 1'b0;
		end else if (ce) begin
			coreIrq <= |deliver;
		end
	end

	// vector towards the core
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			coreVector <= 8'h00;
		end else if (ce) begin
			coreVector <= next_vector;
		end
	end

	// copy of the vector mode bit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vectorModeSelect <= 1'b0;
		end else if (ce) begin
			vectorModeSelect <= ctrl.vecMode;
		end
	end

	// timer running flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			proxTimerActive <= 1'b0;
		end else if (ce) begin
			proxTimerActive <= (proxState == intc_cfg_pkg::PROX_RUN);
		end
	end

	// read data mux, unused bits zero
	always_comb begin
		next_rdData = 32'h0000_0000;
		case (busReq.addr)
			`OFS_CONTROL: begin
				next_rdData[`POS_VEC_MODE] = ctrl.vecMode;
				next_rdData[`POS_THRESH_HI:`POS_THRESH_LO] =
					ctrl.proxThresh;
				next_rdData[`POS_EDGE_HI:`POS_EDGE_LO] = ctrl.edgeSel;
			end
			`OFS_STATUS: begin
				next_rdData[NSRC-1:0] = status;
			end
			`OFS_MASK: begin
				next_rdData[NSRC-1:0] = mask;
			end
			`OFS_PRIORITY: begin
				next_rdData[NUM_EXT*PRIO_W-1:0] = groupPrio;
			end
			`OFS_PROX_TIME: begin
				next_rdData[PROX_W-1:0] = proxTime;
			end
			`OFS_VECTOR: begin
				next_rdData[7:0] = coreVector;
			end
			default: begin
				next_rdData = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdData <= 32'h0000_0000;
		end else if (ce) begin
			rdData <= busReq.rdStb ? next_rdData : 32'h0000_0000;
		end
	end

endmodule

// File: tb/intc_cfg_properties.sv
// assertions on the configuration block ports
`timescale 1ns/1ps
module intc_cfg_properties #(
	parameter int NUM_EXT = 5
) (
	// clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rst,
	input wire logic                   ce,
	// register port
	input wire intc_cfg_pkg::bus_req_t busReq,
	input wire logic [31:0]            rdData,
	// pins and core side
	input wire logic [NUM_EXT-1:0]     extIrqPin,
	input wire logic                   coreIrq,
	input wire logic [7:0]             coreVector,
	input wire logic                   vectorModeSelect,
	input wire logic                   proxTimerActive
);
	logic        wrCtrl;
	logic        rdCtrl;
	logic [12:0] ctrl;
	logic [5:0]  mask;
	assign wrCtrl = ce && busReq.wrStb && busReq.addr == 8'h00;
	assign rdCtrl = ce && busReq.rdStb && busReq.addr == 8'h00;
	// shadow of control
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= 13'h0000;
		end else if (wrCtrl) begin
			ctrl <= busReq.wrData[12:0] & 13'h171F;
		end
	end
	// shadow of mask
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask <= 6'h00;
		end else if (ce && busReq.wrStb && busReq.addr == 8'h08) begin
			mask <= busReq.wrData[5:0];
		end
	end
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_mode_write: assert property (
		wrCtrl |-> ##2 vectorModeSelect == $past(busReq.wrData[12], 2))
		else $error("vector mode not applied");
	a_single_vector: assert property (
		(!vectorModeSelect)[*2] |-> coreVector == 8'h00)
		else $error("vector not zero in single mode");
	a_ctrl_readback: assert property (
		$past(rdCtrl) |-> rdData[12:0] == ctrl)
		else $error("control readback wrong");
	a_prox_disabled: assert property (
		(ctrl[10:8] == 3'h0)[*3] |-> !proxTimerActive)
		else $error("timer runs while disabled");
	a_upper_zero: assert property (
		$past(rdCtrl) |-> rdData[31:13] == 19'h0 && rdData[7:5] == 3'h0)
		else $error("reserved bits not zero");
	a_gap_zero: assert property (
		$past(rdCtrl) |-> !rdData[11])
		else $error("bit 11 not zero");
	a_reset_clean: assert property (
		$fell(rst) |-> !coreIrq && !vectorModeSelect && !proxTimerActive)
		else $error("outputs not clear after reset");
	a_masked_quiet: assert property (
		(mask == 6'h00)[*3] |-> !coreIrq)
		else $error("request while all masked");
	c_multi_irq: cover property (coreIrq && vectorModeSelect);
	c_prox_run: cover property ($rose(proxTimerActive));
	c_ctrl_write: cover property (wrCtrl);
endmodule

// File: tb/core_irq_model.sv
// processor core model taking requests and vectors
`timescale 1ns/1ps
module core_irq_model #(
	parameter int LAT = 2
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// requests from the controller
	input  wire logic       coreIrq,
	input  wire logic [7:0] coreVector,
	// what the core took
	output logic      [7:0] takenVector,
	output logic      [7:0] takenCount
);
	int waitCnt;
	// take the vector after LAT cycles of steady request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			waitCnt <= 0;
			takenVector <= 8'h00;
			takenCount <= 8'h00;
		end else if (!coreIrq) begin
			waitCnt <= 0;
		end else if (waitCnt <= LAT) begin
			waitCnt <= waitCnt + 1;
			if (waitCnt == LAT) begin
				takenVector <= coreVector;
				takenCount <= takenCount + 8'h01;
			end
		end
	end
endmodule

// File: tb/interrupt_control_config_bench.sv
// testbench of the interrupt configuration block
`timescale 1ns/1ps
module interrupt_control_config_bench;
	logic                   sys_clk;
	logic                   rst;
	logic                   ce;
	intc_cfg_pkg::bus_req_t busReq;
	logic [31:0]            rdData;
	logic [4:0]             pins;
	logic                   coreIrq;
	logic [7:0]             coreVector;
	logic                   vectorModeSelect;
	logic                   proxTimerActive;
	logic [7:0]             takenVector;
	logic [7:0]             takenCount;
	int                     mismatches;
	int                     nCompared;
	int                     cycles;

	interrupt_control_config i_interrupt_control_config (
		.sys_clk(sys_clk), .rst(rst), .ce(ce), .busReq(busReq),
		.rdData(rdData), .extIrqPin(pins), .coreIrq(coreIrq),
		.coreVector(coreVector), .vectorModeSelect(vectorModeSelect),
		.proxTimerActive(proxTimerActive));
	core_irq_model i_core_irq_model (
		.sys_clk(sys_clk), .rst(rst), .coreIrq(coreIrq),
		.coreVector(coreVector), .takenVector(takenVector),
		.takenCount(takenCount));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task report_and_stop;
		if (mismatches == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
		@(posedge sys_clk);
		busReq.wrStb <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		busReq.addr <= a;
		busReq.rdStb <= 1'b1;
		@(posedge sys_clk);
		busReq.rdStb <= 1'b0;
		#1;
		check(rdData, exp);
	endtask
	task setPins(input logic [4:0] v);
		@(posedge sys_clk);
		pins <= v;
	endtask
	task proxCase(input logic [2:0] thr, input int src, input logic held);
		wr(8'h00, {21'h0, thr, 8'h1F});
		setPins(5'h01 << src);
		idle(8);
		check({31'h0, proxTimerActive}, {31'h0, held});
		check({31'h0, coreIrq}, {31'h0, !held});
		idle(30);
		check({31'h0, coreIrq}, 32'h1);
		rdchk(8'h04, (32'h1 << src) | (held ? 32'h20 : 32'h0));
		setPins(5'h00);
		idle(6);
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		busReq = '0;
		pins = 5'h00;
		mismatches = 0;
		nCompared = 0;
		cycles = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rdchk(8'h00, 32'h0);
		rdchk(8'h10, 32'h10);
		wr(8'h00, 32'hFFFF_FFFF);
		rdchk(8'h00, 32'h171F);
		idle(2);
		check({31'h0, vectorModeSelect}, 32'h1);
		wr(8'h00, 32'h0);
		idle(2);
		check({31'h0, vectorModeSelect}, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rdchk(8'hFC, 32'h0);
		// edge polarity mix, all masked, then all unmasked
		wr(8'h00, 32'h15);
		setPins(5'h1F);
		idle(8);
		rdchk(8'h04, 32'h15);
		rdchk(8'h04, 32'h0);
		check({31'h0, coreIrq}, 32'h0);
		setPins(5'h00);
		idle(8);
		wr(8'h08, 32'h3F);
		idle(3);
		check({31'h0, coreIrq}, 32'h1);
		rdchk(8'h04, 32'h0A);
		idle(3);
		check({31'h0, coreIrq}, 32'h0);
		// multi and single vector
		wr(8'h0C, 32'h4ED1);
		wr(8'h00, 32'h101F);
		setPins(5'h04);
		idle(10);
		check({24'h0, coreVector}, 32'h03);
		check({24'h0, takenVector}, 32'h03);
		check({24'h0, takenCount}, 32'h02);
		rdchk(8'h14, 32'h03);
		wr(8'h00, 32'h001F);
		idle(3);
		check({24'h0, coreVector}, 32'h00);
		rdchk(8'h04, 32'h04);
		setPins(5'h00);
		idle(8);
		proxCase(3'h0, 0, 1'b0);
		proxCase(3'h1, 0, 1'b1);
		proxCase(3'h1, 1, 1'b0);
		proxCase(3'h2, 1, 1'b1);
		proxCase(3'h2, 2, 1'b0);
		proxCase(3'h7, 3, 1'b1);
		proxCase(3'h3, 4, 1'b0);
		// threshold zero aborts a running timer
		wr(8'h00, 32'h011F);
		setPins(5'h01);
		idle(8);
		check({31'h0, proxTimerActive}, 32'h1);
		wr(8'h00, 32'h001F);
		idle(3);
		check({31'h0, proxTimerActive}, 32'h0);
		check({31'h0, coreIrq}, 32'h1);
		rdchk(8'h04, 32'h01);
		setPins(5'h00);
		idle(6);
		// reset in mid-run
		wr(8'h00, 32'h171F);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rdchk(8'h00, 32'h0);
		check({31'h0, vectorModeSelect}, 32'h0);
		report_and_stop();
	end
endmodule

bind interrupt_control_config intc_cfg_properties #(
	.NUM_EXT(NUM_EXT)
) i_intc_cfg_properties (
	.sys_clk(sys_clk), .rst(rst), .ce(ce), .busReq(busReq),
	.rdData(rdData), .extIrqPin(extIrqPin), .coreIrq(coreIrq),
	.coreVector(coreVector), .vectorModeSelect(vectorModeSelect),
	.proxTimerActive(proxTimerActive));
